// file: boundary_scan_tap.sv
// Boundary-scan port: instruction register, boundary chain, bypass bit and pin muxing.
// Assumes test pins and pad inputs are asynchronous; core drive signals are on core_clk.
`timescale 1ns/1ps
module boundary_scan_tap
	import tap_pkg::*;
(
	input wire logic core_clk, // core clock, 100 MHz
	input wire logic nrst, // async reset, active low
	input wire logic tck, // test clock pin
	input wire logic tms, // test mode select pin
	input wire logic tdi, // test serial data in pin
	output logic tdo, // test serial data out
	output logic tdo_oe_n, // serial out enable, low drives
	input wire logic [N_IN-1:0] pin_in, // pure input pads
	input wire logic [N_OUT-1:0] core_out, // core value for output pads
	input wire logic [N_OUT-1:0] core_out_en, // core enable for output pads
	output logic [N_OUT-1:0] pin_out, // output pad value
	output logic [N_OUT-1:0] pin_out_oe_n, // output pad enable, low drives
	input wire logic [N_BI-1:0] bi_in, // bidirectional pad level
	input wire logic [N_BI-1:0] core_bi_out, // core value for bidirectional pads
	input wire logic [N_BI-1:0] core_bi_en, // core enable for bidirectional pads
	output logic [N_BI-1:0] bi_out, // bidirectional pad value
	output logic [N_BI-1:0] bi_oe_n, // bidirectional pad enable, low drives
	output logic extest_active // pads under chain control
);
	tap_ctl_if ctl ();

	logic [2:0] jtag_sync;
	logic [N_BI+N_IN-1:0] pad_sync;
	logic tck_s;
	logic tdi_s;
	logic tck_d_ff;
	logic tck_fall;
	tap_state_t st;

	tap_sync #(.W(3)) u_sync_jtag (
		.core_clk(core_clk),
		.nrst(nrst),
		.d({tck, tms, tdi}),
		.q(jtag_sync)
	);

	tap_sync #(.W(N_BI + N_IN)) u_sync_pads (
		.core_clk(core_clk),
		.nrst(nrst),
		.d({bi_in, pin_in}),
		.q(pad_sync)
	);

	tap_fsm u_fsm (
		.core_clk(core_clk),
		.nrst(nrst),
		.ctl(ctl)
	);

	assign tck_s = jtag_sync[2];
	assign tdi_s = jtag_sync[0];
	assign ctl.tms = jtag_sync[1];
	assign ctl.tck_rise = tck_s & ~tck_d_ff;
	assign tck_fall = ~tck_s & tck_d_ff;
	assign st = ctl.state;

	// Edge finder looks only at the synchronised level
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tck_d_ff <= 1'b0;
		end else begin
			tck_d_ff <= tck_s;
		end
	end

	// Instruction register
	logic [IR_W-1:0] ir_sh_ff;
	logic [IR_W-1:0] ir_ff;
	logic [IR_W-1:0] nxt_ir_sh;
	logic [IR_W-1:0] nxt_ir;
	logic bsr_sel;
	logic extest;

	// Only two codes reach the chain; everything else, all-ones included, is bypass
	assign extest = (ir_ff == OP_EXTEST);
	assign bsr_sel = extest || (ir_ff == OP_SAMPLE);

	always_comb begin
		nxt_ir_sh = ir_sh_ff;
		nxt_ir = ir_ff;
		if (st == ST_RESET) begin
			nxt_ir = IR_RESET;
		end else if (ctl.tck_rise) begin
			if (st == ST_CAPTURE_IR) begin
				nxt_ir_sh = IR_CAPTURE;
			end else if (st == ST_SHIFT_IR) begin
				nxt_ir_sh = {tdi_s, ir_sh_ff[IR_W-1:1]};
			end
		end else if (tck_fall && st == ST_UPDATE_IR) begin
			nxt_ir = ir_sh_ff;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ir_sh_ff <= IR_CAPTURE;
			ir_ff <= IR_RESET;
		end else begin
			ir_sh_ff <= nxt_ir_sh;
			ir_ff <= nxt_ir;
		end
	end

	// Data registers: chain shift stages, chain output latch, bypass bit
	logic [CHAIN_LEN-1:0] bsr_sh_ff;
	logic [CHAIN_LEN-1:0] bsr_upd_ff;
	logic byp_ff;
	logic [CHAIN_LEN-1:0] nxt_bsr_sh;
	logic [CHAIN_LEN-1:0] nxt_bsr_upd;
	logic nxt_byp;

	always_comb begin
		nxt_bsr_sh = bsr_sh_ff;
		nxt_bsr_upd = bsr_upd_ff;
		nxt_byp = byp_ff;
		if (ctl.tck_rise && st == ST_CAPTURE_DR) begin
			if (bsr_sel) begin
				// Output cells have no parallel input and keep their bits
				for (int i = 0; i < N_IN; i++) begin
					nxt_bsr_sh[IN_BASE + i] = pad_sync[i];
				end
				for (int j = 0; j < N_BI; j++) begin
					nxt_bsr_sh[BI_BASE + 3 * j] = pad_sync[N_IN + j];
				end
			end else begin
				nxt_byp = 1'b0;
			end
		end else if (ctl.tck_rise && st == ST_SHIFT_DR) begin
			if (bsr_sel) begin
				nxt_bsr_sh = {tdi_s, bsr_sh_ff[CHAIN_LEN-1:1]};
			end else begin
				nxt_byp = tdi_s;
			end
		end else if (tck_fall && st == ST_UPDATE_DR && bsr_sel) begin
			nxt_bsr_upd = bsr_sh_ff;
		end
	end

	// Pause and exit states fall through with everything held
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bsr_sh_ff <= CHAIN_RESET;
			bsr_upd_ff <= CHAIN_RESET;
			byp_ff <= 1'b0;
		end else begin
			bsr_sh_ff <= nxt_bsr_sh;
			bsr_upd_ff <= nxt_bsr_upd;
			byp_ff <= nxt_byp;
		end
	end

	// Serial out changes on the falling test clock so the tester samples a settled bit
	logic tdo_ff;
	logic tdo_oe_n_ff;
	logic nxt_tdo;
	logic nxt_tdo_oe_n;

	always_comb begin
		nxt_tdo = tdo_ff;
		nxt_tdo_oe_n = tdo_oe_n_ff;
		if (tck_fall) begin
			if (st == ST_SHIFT_DR) begin
				nxt_tdo = bsr_sel ? bsr_sh_ff[0] : byp_ff;
				nxt_tdo_oe_n = 1'b0;
			end else if (st == ST_SHIFT_IR) begin
				nxt_tdo = ir_sh_ff[0];
				nxt_tdo_oe_n = 1'b0;
			end else begin
				nxt_tdo_oe_n = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tdo_ff <= 1'b0;
			tdo_oe_n_ff <= 1'b1;
		end else begin
			tdo_ff <= nxt_tdo;
			tdo_oe_n_ff <= nxt_tdo_oe_n;
		end
	end

	// Pad muxing; registered, so pads lag the core by one clock
	logic [N_OUT-1:0] pin_out_ff;
	logic [N_OUT-1:0] pin_out_oe_n_ff;
	logic [N_BI-1:0] bi_out_ff;
	logic [N_BI-1:0] bi_oe_n_ff;
	logic extest_ff;
	logic [N_OUT-1:0] nxt_pin_out;
	logic [N_OUT-1:0] nxt_pin_out_oe_n;
	logic [N_BI-1:0] nxt_bi_out;
	logic [N_BI-1:0] nxt_bi_oe_n;

	always_comb begin
		nxt_pin_out = core_out;
		nxt_pin_out_oe_n = ~core_out_en;
		nxt_bi_out = core_bi_out;
		nxt_bi_oe_n = ~core_bi_en;
		if (extest) begin
			for (int k = 0; k < N_OUT; k++) begin
				nxt_pin_out[k] = bsr_upd_ff[OUT_BASE + 2 * k];
				nxt_pin_out_oe_n[k] = ~bsr_upd_ff[OUT_BASE + 2 * k + 1];
			end
			for (int m = 0; m < N_BI; m++) begin
				nxt_bi_out[m] = bsr_upd_ff[BI_BASE + 3 * m + 1];
				nxt_bi_oe_n[m] = ~bsr_upd_ff[BI_BASE + 3 * m + 2];
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_out_ff <= '0;
			pin_out_oe_n_ff <= '1;
			bi_out_ff <= '0;
			bi_oe_n_ff <= '1;
			extest_ff <= 1'b0;
		end else begin
			pin_out_ff <= nxt_pin_out;
			pin_out_oe_n_ff <= nxt_pin_out_oe_n;
			bi_out_ff <= nxt_bi_out;
			bi_oe_n_ff <= nxt_bi_oe_n;
			extest_ff <= extest;
		end
	end

	assign tdo = tdo_ff;
	assign tdo_oe_n = tdo_oe_n_ff;
	assign pin_out = pin_out_ff;
	assign pin_out_oe_n = pin_out_oe_n_ff;
	assign bi_out = bi_out_ff;
	assign bi_oe_n = bi_oe_n_ff;
	assign extest_active = extest_ff;
endmodule

// file: boundary_scan_tap_assertions.sv
// Checker for the boundary-scan port, bound to its top-level ports.
// Assumes the test clock is slow; its edges are found again here on core_clk.
`timescale 1ns/1ps
module boundary_scan_tap_assertions
	import tap_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic nrst, // reset, low
	input wire logic tck, // test clock
	input wire logic tms, // mode select
	input wire logic tdo, // serial out
	input wire logic tdo_oe_n, // serial out enable
	input wire logic [N_OUT-1:0] core_out, // core value
	input wire logic [N_OUT-1:0] core_out_en, // core enable
	input wire logic [N_OUT-1:0] pin_out, // pad value
	input wire logic [N_OUT-1:0] pin_out_oe_n, // pad enable
	input wire logic extest_active // chain drives pads
);
	logic tck_q;
	logic tms_r;
	logic [3:0] fage;
	logic [3:0] rage;
	logic [2:0] hi_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Ages saturate so long idle gaps compare as old
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tck_q <= 1'b0;
			tms_r <= 1'b0;
			fage <= 4'hf;
			rage <= 4'hf;
			hi_cnt <= 3'h0;
		end else begin
			tck_q <= tck;
			fage <= (!tck && tck_q) ? 4'h0 : fage + {3'h0, fage != 4'hf};
			rage <= (tck && !tck_q) ? 4'h0 : rage + {3'h0, rage != 4'hf};
			if (tck && !tck_q) begin
				tms_r <= tms;
				hi_cnt <= tms ? hi_cnt + {2'h0, hi_cnt != 3'h7} : 3'h0;
			end
		end
	end
	AST_TDO_EDGE: assert property ($changed(tdo) || $changed(tdo_oe_n) |-> fage <= 4'h6)
		else $error("serial out moved away from a test clock fall");
	AST_OE_EXIT: assert property (fage == 4'h8 && tms_r |-> tdo_oe_n)
		else $error("serial out driven outside a shift state");
	AST_OE_START: assert property ($fell(tdo_oe_n) |-> !tms_r && fage <= 4'h6)
		else $error("serial out enabled without a shift entry");
	AST_TLR: assert property (hi_cnt >= 3'h5 && rage > 4'h8 |-> !extest_active && tdo_oe_n)
		else $error("five high mode select edges did not reset the port");
	AST_EXT_CHANGE: assert property ($changed(extest_active) |-> fage <= 4'h6 || rage <= 4'h6)
		else $error("instruction changed with the test clock idle");
	AST_PAD_VAL: assert property (fage > 4'h8 && rage > 4'h8 && !extest_active && $past(nrst)
		|-> pin_out == $past(core_out))
		else $error("pad value does not follow core");
	AST_PAD_EN: assert property (fage > 4'h8 && rage > 4'h8 && !extest_active && $past(nrst)
		|-> pin_out_oe_n == ~$past(core_out_en))
		else $error("pad enable does not follow core");
	AST_EXT_HOLD: assert property (extest_active && fage > 4'h8
		|-> $stable(pin_out) && $stable(pin_out_oe_n))
		else $error("chain driven pads changed outside an update");
endmodule
bind boundary_scan_tap boundary_scan_tap_assertions chk_u (.core_clk(core_clk), .nrst(nrst),
	.tck(tck), .tms(tms), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out),
	.core_out_en(core_out_en), .pin_out(pin_out), .pin_out_oe_n(pin_out_oe_n),
	.extest_active(extest_active));

// file: scan_tester.sv
// Tester model: drives test clock, mode select and serial data, reads serial out.
// Assumes an 80 ns test clock that stands low between frames; idle data sits high.
`timescale 1ns/1ps
module scan_tester (
	output logic tck, // test clock
	output logic tms, // mode select
	output logic tdi, // serial data in
	input wire logic tdo // serial data out
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// Set up a half period before the rise, hold a half period after it
	task automatic step(input logic m, input logic v, output logic o);
		tms = m;
		tdi = v;
		#40 tck = 1'b1;
		#40 o = tdo;
		tck = 1'b0;
	endtask
	task automatic scan(input logic ir, input int n, input int pz, input logic [62:0] din,
		output logic [62:0] dout);
		logic b;
		dout = '0;
		// Leaves reset for idle first; a port already idle stays there
		step(1'b0, 1'b1, b);
		step(1'b1, 1'b1, b);
		if (ir) step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		step(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pz, din[i], dout[i]);
			if (i == pz) begin
				step(1'b0, 1'b1, b);
				step(1'b0, 1'b1, b);
				step(1'b1, 1'b1, b);
				step(1'b0, 1'b1, b);
			end
		end
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		#100;
	endtask
endmodule

// file: tap_ctl_if.sv
// Carries controller state and sampled test-pin events between the port and its controller.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface tap_ctl_if;
	import tap_pkg::*;
	logic tck_rise;
	logic tms;
	tap_state_t state;
	modport fsm (input tck_rise, input tms, output state);
	modport core (output tck_rise, output tms, input state);
endinterface

// file: tap_fsm.sv
// Sixteen-state test access port controller, stepped on sampled test-clock rising edges.
// Assumes mode select is sampled with the same delay as the test clock.
`timescale 1ns/1ps
module tap_fsm
	import tap_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic nrst, // async reset, active low
	tap_ctl_if.fsm ctl // edge event, mode select and state
);
	tap_state_t state_ff;
	tap_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (ctl.tck_rise) begin
			unique case (state_ff)
				ST_RESET: nxt_state = ctl.tms ? ST_RESET : ST_IDLE;
				ST_IDLE: nxt_state = ctl.tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: nxt_state = ctl.tms ? ST_SEL_IR : ST_CAPTURE_DR;
				ST_CAPTURE_DR: nxt_state = ctl.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_SHIFT_DR: nxt_state = ctl.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_EXIT1_DR: nxt_state = ctl.tms ? ST_UPDATE_DR : ST_PAUSE_DR;
				ST_PAUSE_DR: nxt_state = ctl.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
				ST_EXIT2_DR: nxt_state = ctl.tms ? ST_UPDATE_DR : ST_SHIFT_DR;
				ST_UPDATE_DR: nxt_state = ctl.tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR: nxt_state = ctl.tms ? ST_RESET : ST_CAPTURE_IR;
				ST_CAPTURE_IR: nxt_state = ctl.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_SHIFT_IR: nxt_state = ctl.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_EXIT1_IR: nxt_state = ctl.tms ? ST_UPDATE_IR : ST_PAUSE_IR;
				ST_PAUSE_IR: nxt_state = ctl.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
				ST_EXIT2_IR: nxt_state = ctl.tms ? ST_UPDATE_IR : ST_SHIFT_IR;
				ST_UPDATE_IR: nxt_state = ctl.tms ? ST_SEL_DR : ST_IDLE;
			endcase
		end
	end

	// Power-up lands in reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign ctl.state = state_ff;
endmodule

// file: tap_pkg.sv
// Constants, types and chain layout for the boundary-scan test access port.
// Assumes a single core clock domain; the test pins are sampled, not used as clocks.
package tap_pkg;

	typedef enum logic [3:0] {
		ST_RESET      = 4'h0,
		ST_IDLE       = 4'h1,
		ST_SEL_DR     = 4'h2,
		ST_CAPTURE_DR = 4'h3,
		ST_SHIFT_DR   = 4'h4,
		ST_EXIT1_DR   = 4'h5,
		ST_PAUSE_DR   = 4'h6,
		ST_EXIT2_DR   = 4'h7,
		ST_UPDATE_DR  = 4'h8,
		ST_SEL_IR     = 4'h9,
		ST_CAPTURE_IR = 4'ha,
		ST_SHIFT_IR   = 4'hb,
		ST_EXIT1_IR   = 4'hc,
		ST_PAUSE_IR   = 4'hd,
		ST_EXIT2_IR   = 4'he,
		ST_UPDATE_IR  = 4'hf
	} tap_state_t;

	localparam int IR_W = 2;
	localparam logic [IR_W-1:0] OP_EXTEST = 2'h0;
	localparam logic [IR_W-1:0] OP_SAMPLE = 2'h1;
	localparam logic [IR_W-1:0] OP_BYPASS = 2'h3;
	localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
	localparam logic [IR_W-1:0] IR_RESET = OP_BYPASS;

	localparam int N_IN = 12;
	localparam int N_OUT = 6;
	localparam int N_BI = 13;
	localparam int IN_BASE = 0;
	localparam int OUT_BASE = IN_BASE + N_IN;
	localparam int BI_BASE = OUT_BASE + 2 * N_OUT;
	localparam int CHAIN_LEN = BI_BASE + 3 * N_BI;
	localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = '0;

endpackage

// file: tap_sync.sv
// Two-flop synchroniser for a group of levels from outside the core clock domain.
// Assumes each bit may change at any time; no bus coherence is promised.
`timescale 1ns/1ps
module tap_sync #(
	parameter int W = 1
) (
	input wire logic core_clk, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

// file: tb_boundary_scan_tap.sv
// Testbench: instruction rows in a table, then full chain, extest and reset cases.
// Assumes scan_tester drives the test pins and the checker is bound to the port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %0h seen %0h", nm, e, g); end end
module tb_boundary_scan_tap;
	import tap_pkg::*;
	typedef struct {logic [1:0] code; logic ext; logic byp;} row_t;
	row_t rows [4] = '{'{2'h3, 1'b0, 1'b1}, '{2'h2, 1'b0, 1'b1}, '{2'h0, 1'b1, 1'b0},
		'{2'h1, 1'b0, 1'b0}};
	localparam logic [62:0] PAT = 63'h2a3c96e10f7b2d48;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe_n, extest_active, b;
	logic [N_IN-1:0] pin_in = 12'ha5c;
	logic [N_OUT-1:0] core_out = 6'h2d, core_out_en = 6'h33, pin_out, pin_out_oe_n;
	logic [N_BI-1:0] core_bi_out = 13'h1c35, core_bi_en = 13'h0f0f, bi_ext = 13'h16a9;
	logic [N_BI-1:0] bi_in, bi_out, bi_oe_n;
	logic [62:0] d;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	assign bi_in = (~bi_oe_n & bi_out) | (bi_oe_n & bi_ext);
	always #5 core_clk = ~core_clk;
	scan_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	boundary_scan_tap dut_u (.core_clk(core_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
		.core_out_en(core_out_en), .pin_out(pin_out), .pin_out_oe_n(pin_out_oe_n),
		.bi_in(bi_in), .core_bi_out(core_bi_out), .core_bi_en(core_bi_en), .bi_out(bi_out),
		.bi_oe_n(bi_oe_n), .extest_active(extest_active));
	function automatic logic [12:0] gather(input logic [62:0] v, input int base, stride, n);
		logic [12:0] r;
		r = '0;
		for (int i = 0; i < n; i++) r[i] = v[base + stride * i];
		return r;
	endfunction
	function automatic logic [12:0] pad_level(input logic [12:0] en, val);
		return (en & val) | (~en & bi_ext);
	endfunction
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge core_clk) #1 nrst = 1'b0;
		repeat (4) @(posedge core_clk);
		`CHK("reset outs", 21'h1ffffd, {pin_out_oe_n, bi_oe_n, extest_active, tdo_oe_n})
		#1 nrst = 1'b1;
		repeat (3) @(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		do_reset();
		foreach (rows[i]) begin
			tst.scan(1'b1, 2, -1, {61'h0, rows[i].code}, d);
			`CHK("ir capture", 2'h1, d[1:0])
			`CHK("extest_active", rows[i].ext, extest_active)
			tst.scan(1'b0, 4, -1, 63'hb, d);
			`CHK("dr out", rows[i].byp ? 4'h6 : pin_in[3:0], d[3:0])
		end
		tst.scan(1'b0, 63, 30, PAT, d);
		`CHK("input cells", {1'b0, pin_in}, gather(d, 0, 1, 12))
		`CHK("bidir capture", pad_level(core_bi_en, core_bi_out), gather(d, 24, 3, 13))
		`CHK("pads follow", {core_out, core_bi_out}, {pin_out, bi_out})
		tst.scan(1'b1, 2, -1, 63'h0, d);
		@(posedge core_clk) #1 core_out = ~core_out;
		repeat (3) @(posedge core_clk);
		`CHK("extest_active", 1'b1, extest_active)
		`CHK("out cells", {gather(PAT, 12, 2, 6), ~gather(PAT, 13, 2, 6)},
			{7'h0, pin_out, 7'h7f, pin_out_oe_n})
		`CHK("bidir cells", {gather(PAT, 25, 3, 13), ~gather(PAT, 26, 3, 13)},
			{bi_out, bi_oe_n})
		tst.scan(1'b0, 63, -1, ~PAT, d);
		`CHK("ext capture", pad_level(gather(PAT, 26, 3, 13), gather(PAT, 25, 3, 13)),
			gather(d, 24, 3, 13))
		`CHK("new pads", gather(~PAT, 12, 2, 6), {7'h0, pin_out})
		tst.step(1'b1, 1'b1, b);
		tst.step(1'b0, 1'b1, b);
		tst.step(1'b0, 1'b1, b);
		repeat (5) tst.step(1'b1, 1'b1, b);
		#100 `CHK("tms reset", {1'b0, core_out}, {extest_active, pin_out})
		tst.step(1'b0, 1'b1, b);
		tst.scan(1'b0, 4, -1, 63'hb, d);
		`CHK("reset bypass", 4'h6, d[3:0])
		tst.scan(1'b1, 2, -1, 63'h0, d);
		do_reset();
		`CHK("after reset", {1'b0, core_out}, {extest_active, pin_out})
		tst.scan(1'b1, 2, -1, 63'h1, d);
		`CHK("ir capture", 2'h1, d[1:0])
		stop_test();
	end
endmodule
